/* rtl/fan_led_pwm_generator.sv */
// Pulse width modulation generator with AHB-Lite register slave.
// Assumes a single AHB-Lite master, word registers, one 250 MHz clock.
//
// Summary of operation
// [R1] Counter runs from a fast 48 MHz or slow 100 kHz source.
// [R2] Source select is config bit 1, pre-divider is bits 6 to 3.
// [R3] Output stays on for high count plus one divided ticks.
// [R4] High count zero with low count nonzero holds output off.
// [R5] Output toggles, holds on, or holds off.
// [R6] Period is divider plus one times both counts plus two.
// [R7] Duty is high count plus one over the total.
// [R8] Any duty from below 0.1 Hz up to 12 MHz output.
// [R9] Sleep clears counters and forces state and output off.
// [R10] No interrupts are generated.
// [R11] System reset returns all registers and logic to defaults.
// [R12] Software should access the count registers as 16-bit values.
// [R13] Count writes land in holding registers at any time.
// [R14] Holding copies to active after four bytes and low phase end.
// [R15] In full-on state the copy happens once four bytes are written.
// [R16] After a copy the holding bytes must all be rewritten.
// [R17] Count reads return the active values, not holding.
// [R18] Output off for low count plus one ticks; zero low is full on.
// [R19] Source is divided by pre-divider plus one; zero means none.
// [R20] Enable clear resets counters and state, output inactive.
// [R21] Invert bit one makes the on state active low.
// [R22] Counter reloads per phase and advances phase at zero.
// [R23] Source ticks are enable pulses in the register clock.
`timescale 1ns/1ps
module fan_led_pwm_generator (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Power control
    input  wire logic        sleep_req,
    // Load pin
    output logic             modulated_pin
);
    import pwm_pkg::*;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic              wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [3:0]        wr_lanes_q;
    logic              acc_ok;
    logic [3:0]        lanes_d;
    logic [3:0]        hold_we;
    logic              cfg_we;
    logic [31:0]       held;
    logic              held_full;
    logic              hold_clear;

    assign acc_ok = hsel && hready && htrans[1];

    always_comb begin
        case (hsize)
            HSIZE_BYTE: lanes_d = 4'h1 << haddr[1:0];
            HSIZE_HALF: lanes_d = haddr[1] ? 4'hC : 4'h3;
            default:    lanes_d = 4'hF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin // R11
        if (!rst_n) begin
            wr_pend_q  <= 1'b0;
            wr_addr_q  <= '0;
            wr_lanes_q <= BYTES_NONE;
        end else begin
            wr_pend_q  <= acc_ok && hwrite;
            wr_addr_q  <= haddr[ADDR_W-1:0];
            wr_lanes_q <= lanes_d;
        end
    end

    // Count bytes map: high count lanes 0..1, low count lanes 0..1
    always_comb begin // R13
        hold_we = BYTES_NONE;
        if (wr_pend_q && wr_addr_q == HIGH_PHASE_COUNT_OFS[ADDR_W-1:0]) begin
            hold_we[1:0] = wr_lanes_q[1:0];
        end
        if (wr_pend_q && wr_addr_q == LOW_PHASE_COUNT_OFS[ADDR_W-1:0]) begin
            hold_we[3:2] = wr_lanes_q[1:0];
        end
    end
    assign cfg_we = wr_pend_q &&
        wr_addr_q == GENERATOR_CONFIGURATION_OFS[ADDR_W-1:0] && wr_lanes_q[0];

    pwm_holding u_hold (
        .clk     (clk),
        .rst_n   (rst_n),
        .byte_we (hold_we),
        .wdata   (hwdata),
        .clear   (hold_clear),
        .held    (held),
        .full    (held_full)
    );

    // ****************************************************************
    // Configuration
    // ****************************************************************
    logic             enable_q;
    logic             slow_sel_q;
    logic             invert_q;
    logic [DIV_W-1:0] pre_div_q;

    always_ff @(posedge clk or negedge rst_n) begin // R2 R11
        if (!rst_n) begin
            enable_q   <= 1'b0;
            slow_sel_q <= 1'b0;
            invert_q   <= 1'b0;
            pre_div_q  <= DIV_ZERO;
        end else if (cfg_we) begin
            enable_q   <= hwdata[CFG_ENABLE];
            slow_sel_q <= hwdata[CFG_SELECT];
            invert_q   <= hwdata[CFG_INVERT];
            pre_div_q  <= hwdata[CFG_DIV_HI:CFG_DIV_LO];
        end
    end

    // ****************************************************************
    // Active counts and tick source
    // ****************************************************************
    logic [CNT_W-1:0] high_cnt_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic             run;
    logic             tick;
    logic             full_on;
    logic             full_off;
    logic             low_done;

    assign run      = enable_q && !sleep_req; // R9 R20
    assign full_on  = (low_cnt_q == CNT_ZERO); // R18
    assign full_off = (high_cnt_q == CNT_ZERO) && !full_on; // R4

    pwm_tick_gen u_tick (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (run),
        .slow_sel (slow_sel_q),
        .pre_div  (pre_div_q),
        .tick     (tick)
    );

    // ****************************************************************
    // Phase machine
    // ****************************************************************
    phase_t           phase_q;
    logic [CNT_W-1:0] cnt_q;
    logic             transfer;

    assign low_done = tick && phase_q == PH_LOW && cnt_q == CNT_ZERO;
    // Copy at end of low phase, immediately when full on or idle
    assign transfer = held_full &&
        (low_done || full_on || phase_q == PH_OFF); // R14 R15
    assign hold_clear = transfer; // R16

    always_ff @(posedge clk or negedge rst_n) begin // R14 R15 R11
        if (!rst_n) begin
            high_cnt_q <= HIGH_RST;
            low_cnt_q  <= LOW_RST;
        end else if (transfer) begin
            high_cnt_q <= held[15:0];
            low_cnt_q  <= held[31:16];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin // R22 R3 R18 R6 R7
        if (!rst_n) begin
            phase_q <= PH_OFF;
            cnt_q   <= CNT_ZERO;
        end else if (!run) begin // R9 R20
            phase_q <= PH_OFF;
            cnt_q   <= CNT_ZERO;
        end else begin
            case (phase_q)
                PH_OFF: begin
                    phase_q <= PH_HIGH;
                    cnt_q   <= high_cnt_q;
                end
                PH_HIGH: begin
                    if (tick && cnt_q == CNT_ZERO) begin
                        phase_q <= PH_LOW;
                        cnt_q   <= low_cnt_q;
                    end else if (tick) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                PH_LOW: begin
                    if (low_done) begin
                        phase_q <= PH_HIGH;
                        cnt_q   <= transfer ? held[15:0] : high_cnt_q;
                    end else if (tick) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    phase_q <= PH_OFF;
                    cnt_q   <= CNT_ZERO;
                end
            endcase
        end
    end

    // ****************************************************************
    // Output pin
    // ****************************************************************
    logic on_level;

    always_comb begin // R5
        if (!run || phase_q == PH_OFF) begin
            on_level = 1'b0;
        end else if (full_on) begin
            on_level = 1'b1;
        end else if (full_off) begin
            on_level = 1'b0;
        end else begin
            on_level = (phase_q == PH_HIGH);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin // R21
        if (!rst_n) begin
            modulated_pin <= 1'b0;
        end else begin
            modulated_pin <= on_level ^ invert_q;
        end
    end

    // ****************************************************************
    // Read data and response
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin // R17
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (acc_ok && !hwrite) begin
            case (haddr[ADDR_W-1:0])
                HIGH_PHASE_COUNT_OFS[ADDR_W-1:0]:
                    hrdata <= {16'h0000, high_cnt_q};
                LOW_PHASE_COUNT_OFS[ADDR_W-1:0]:
                    hrdata <= {16'h0000, low_cnt_q};
                GENERATOR_CONFIGURATION_OFS[ADDR_W-1:0]:
                    hrdata <= {25'h000_0000, pre_div_q, invert_q,
                               slow_sel_q, enable_q};
                default:
                    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY; no interrupt logic exists
    always_ff @(posedge clk or negedge rst_n) begin // R10
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_DISABLE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !run |=> phase_q == PH_OFF && cnt_q == CNT_ZERO) // R20
        else $error("Counter not cleared while stopped");
    AST_PIN_INACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !run ##1 !run |=> modulated_pin == $past(invert_q)) // R9
        else $error("Pin not inactive while stopped");
    AST_FULL_ON: assert property (@(posedge clk) disable iff (!rst_n)
        run && phase_q != PH_OFF && full_on
        |=> modulated_pin == !$past(invert_q)) // R18
        else $error("Full on not driven");
    AST_FULL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        full_off |=> modulated_pin == $past(invert_q)) // R4
        else $error("Full off not driven");
    AST_CLEAR_AFTER: assert property (@(posedge clk) disable iff (!rst_n)
        transfer |=> !held_full) // R16
        else $error("Holding not emptied");
    AST_NO_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(low_cnt_q) |-> $past(held_full)) // R14
        else $error("Copy without four bytes");
    AST_HIGH_TO_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        run && phase_q == PH_HIGH && tick && cnt_q == CNT_ZERO
        |=> phase_q == PH_LOW || !run) // R22
        else $error("Phase did not advance");
    AST_DECR: assert property (@(posedge clk) disable iff (!rst_n)
        run && phase_q == PH_HIGH && tick && cnt_q != CNT_ZERO
        |=> cnt_q == $past(cnt_q) - 16'h0001 || !run) // R3
        else $error("Counter did not decrement");
    AST_READ_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
        acc_ok && !hwrite && haddr[3:0] == 4'h0
        |=> hrdata[15:0] == $past(high_cnt_q)) // R17
        else $error("Read did not return active count");
    COV_TOGGLE: cover property (@(posedge clk) disable iff (!rst_n)
        phase_q == PH_HIGH ##1 phase_q == PH_LOW);
    COV_TRANSFER: cover property (@(posedge clk) disable iff (!rst_n)
        low_done && transfer);
    COV_FULL_ON: cover property (@(posedge clk) disable iff (!rst_n)
        full_on && transfer);
endmodule : fan_led_pwm_generator

/* shared/pwm_pkg.sv */
// Package of constants for the pulse width modulation generator.
// Assumes a 32-bit AHB-Lite register bus and a 250 MHz register clock.
package pwm_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [31:0] HIGH_PHASE_COUNT_OFS        = 32'h0000_0000;
    localparam logic [31:0] LOW_PHASE_COUNT_OFS         = 32'h0000_0004;
    localparam logic [31:0] GENERATOR_CONFIGURATION_OFS = 32'h0000_0008;
    localparam int          ADDR_W                      = 4;
    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int          CNT_W       = 16;
    localparam int          DIV_W       = 4;
    localparam int          CFG_ENABLE  = 0;
    localparam int          CFG_SELECT  = 1;
    localparam int          CFG_INVERT  = 2;
    localparam int          CFG_DIV_LO  = 3;
    localparam int          CFG_DIV_HI  = 6;
    localparam logic [15:0] HIGH_RST    = 16'h0000;
    localparam logic [15:0] LOW_RST     = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [3:0]  DIV_ZERO    = 4'h0;
    localparam logic [3:0]  BYTES_ALL   = 4'hF;
    localparam logic [3:0]  BYTES_NONE  = 4'h0;
    // ****************************************************************
    // Source clock rates, as enable pulses from the register clock
    // ****************************************************************
    localparam int CLK_MHZ       = 250;
    localparam int FAST_SRC_KHZ  = 48000;
    localparam int SLOW_SRC_KHZ  = 100;
    localparam int ACC_W         = 18;
    localparam logic [17:0] FAST_STEP =
        18'((FAST_SRC_KHZ * 1024) / (CLK_MHZ * 1000) * 256);
    localparam logic [17:0] SLOW_STEP =
        18'((SLOW_SRC_KHZ * 262144) / (CLK_MHZ * 1000));
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic [2:0]  HSIZE_HALF    = 3'h1;
    localparam logic [2:0]  HSIZE_BYTE    = 3'h0;
    typedef enum logic [1:0] {PH_OFF, PH_HIGH, PH_LOW} phase_t;
endpackage : pwm_pkg

/* rtl/pwm_tick_gen.sv */
// Source tick generator: makes enable pulses at the fast or slow
// source rate, then applies the pre-divider.
// Assumes all pulses stay in the register clock domain.
`timescale 1ns/1ps
module pwm_tick_gen (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             run,
    input  wire logic             slow_sel,
    input  wire logic [3:0]       pre_div,
    // Divided tick
    output logic                  tick
);
    import pwm_pkg::*;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0]   acc_sum;
    logic [DIV_W-1:0] div_q;
    logic             src_tick;

    // Phase accumulator gives a source-rate pulse without a second clock
    assign acc_sum  = {1'b0, acc_q} + {1'b0, slow_sel ? SLOW_STEP : FAST_STEP};
    assign src_tick = acc_sum[ACC_W];

    always_ff @(posedge clk or negedge rst_n) begin // R1 R23 R8
        if (!rst_n) begin
            acc_q <= '0;
        end else if (!run) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_sum[ACC_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin // R19
        if (!rst_n) begin
            div_q <= DIV_ZERO;
            tick  <= 1'b0;
        end else if (!run) begin
            div_q <= DIV_ZERO;
            tick  <= 1'b0;
        end else if (src_tick) begin
            tick  <= (div_q >= pre_div);
            div_q <= (div_q >= pre_div) ? DIV_ZERO : div_q + 4'h1;
        end else begin
            tick  <= 1'b0;
        end
    end
endmodule : pwm_tick_gen

/* rtl/pwm_holding.sv */
// Holding registers for the two counts with per-byte written flags.
// Assumes byte lane enables are already decoded from the bus.
`timescale 1ns/1ps
module pwm_holding (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Write side
    input  wire logic [3:0]        byte_we,
    input  wire logic [31:0]       wdata,
    input  wire logic              clear,
    // Held values
    output logic [31:0]            held,
    output logic                   full
);
    import pwm_pkg::*;
    logic [3:0] got_q;

    // Byte 0..1 is the high count, bytes 2..3 the low count
    for (genvar i = 0; i < 4; i++) begin : g_byte
        always_ff @(posedge clk or negedge rst_n) begin // R13
            if (!rst_n) begin
                held[8*i+:8] <= 8'h00;
            end else if (byte_we[i]) begin
                held[8*i+:8] <= wdata[8*(i%2)+:8];
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin // R16
            if (!rst_n) begin
                got_q[i] <= 1'b0;
            end else if (byte_we[i]) begin
                got_q[i] <= 1'b1;
            end else if (clear) begin
                got_q[i] <= 1'b0;
            end
        end
    end
    assign full = (got_q == BYTES_ALL);
endmodule : pwm_holding

/* sim/pwm_load_model.sv */
// Behavioural load on the modulated pin: a fan or LED input that only
// listens, and measures how long each level lasts.
// Assumes the pin is sampled in the 250 MHz register clock domain.
`timescale 1ns/1ps
module pwm_load_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Load pin
    input  wire logic modulated_pin,
    // Last completed run lengths, in clock cycles, and the count of edges
    output int        hi_len,
    output int        lo_len,
    output int        edges
);
    logic last_q;
    int   run_q;

    // ****************************************************************
    // Run length measurement
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b0;
            run_q  <= 0;
            hi_len <= 0;
            lo_len <= 0;
            edges  <= 0;
        end else begin
            last_q <= modulated_pin;
            if (modulated_pin !== last_q) begin
                if (last_q === 1'b1) begin
                    hi_len <= run_q;
                end else begin
                    lo_len <= run_q;
                end
                edges <= edges + 1;
                run_q <= 1;
            end else begin
                run_q <= run_q + 1;
            end
        end
    end
endmodule : pwm_load_model

/* sim/fan_led_pwm_generator_test.sv */
// Self-checking bench: AHB-Lite register tasks and pin measurements.
// Assumes the design answers with zero wait states and the load model
// reports run lengths of the pin.
`timescale 1ns/1ps
module fan_led_pwm_generator_test;
    import pwm_pkg::*;
    localparam int LIM = 40000;
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sleep_req;
    logic        modulated_pin;
    int          hi_len;
    int          lo_len;
    int          edges;
    int          num_errors;
    int          cmp_count;

    assign hready = hreadyout;
    always #2 clk = ~clk;

    fan_led_pwm_generator u_fan_led_pwm_generator (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req),
        .modulated_pin(modulated_pin)
    );
    pwm_load_model u_pwm_load_model (
        .clk(clk), .rst_n(rst_n), .modulated_pin(modulated_pin),
        .hi_len(hi_len), .lo_len(lo_len), .edges(edges)
    );

    // ****************************************************************
    // Reporting and comparison
    // ****************************************************************
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic fail(input string msg);
        num_errors++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask : fail

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask : cmp

    task automatic near(input int got, input int exp, input string msg);
        cmp_count++;
        if (got < exp - 8 || got > exp + 8) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %0d exp %0d",
                     $time, msg, got, exp);
        end
    endtask : near

    // Source pulses of the accumulator, times the pre-divider plus one
    function automatic int exp_cyc(input int ticks, input int div,
                                   input bit slow);
        longint step;
        step = slow ? longint'(SLOW_STEP) : longint'(FAST_STEP);
        return int'(longint'(ticks) * (div + 1) *
                    (longint'(1) << ACC_W) / step);
    endfunction : exp_cyc

    // ****************************************************************
    // Bus and pin tasks
    // ****************************************************************
    task automatic ahb_xfer(input logic w, input logic [31:0] a,
                            input logic [31:0] wd,
                            output logic [31:0] rd);
        int n;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("bus address wait");
            report_and_stop();
        end
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (hresp !== 1'b0) begin
            fail("bus response not OKAY");
        end
        if (n >= 50) begin
            fail("bus wait");
            report_and_stop();
        end
    endtask : ahb_xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb_xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb_xfer(1'b0, a, 32'h0000_0000, r);
        cmp(r, exp, "register read");
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic measure(input int hi_exp, input int lo_exp);
        int e0;
        int n;
        e0 = edges;
        n = 0;
        // Skip runs left over from the previous setting
        while (edges < e0 + 5 && n < LIM) begin
            @(posedge clk);
            n++;
        end
        if (n >= LIM) begin
            fail("pin does not toggle");
            report_and_stop();
        end
        near(hi_len, hi_exp, "high run");
        near(lo_len, lo_exp, "low run");
    endtask : measure

    task automatic steady(input logic lvl, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if (modulated_pin !== lvl) bad = 1'b1;
        end
        cmp({31'h0, bad}, 32'h0000_0000, "pin not steady");
    endtask : steady

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0; rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000;
        htrans = 2'h0; hwrite = 1'b0; hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000; sleep_req = 1'b0;
        num_errors = 0; cmp_count = 0;
        idle(4);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(HIGH_PHASE_COUNT_OFS, 32'h0000_0000);
        rd_chk(LOW_PHASE_COUNT_OFS, 32'h0000_FFFF);
        rd_chk(GENERATOR_CONFIGURATION_OFS, 32'h0000_0000);
        rd_chk(32'h0000_000C, 32'h0000_0000);
        cmp({31'h0, modulated_pin}, 32'h0000_0000, "pin idle");
        wr(HIGH_PHASE_COUNT_OFS, 32'h0000_0003);
        wr(LOW_PHASE_COUNT_OFS, 32'h0000_0005);
        idle(2);
        rd_chk(HIGH_PHASE_COUNT_OFS, 32'h0000_0003);
        rd_chk(LOW_PHASE_COUNT_OFS, 32'h0000_0005);
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0001);
        measure(exp_cyc(4, 0, 0), exp_cyc(6, 0, 0));
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0011);
        measure(exp_cyc(4, 2, 0), exp_cyc(6, 2, 0));
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0001);
        wr(HIGH_PHASE_COUNT_OFS, 32'h0000_0007);
        idle(200);
        rd_chk(HIGH_PHASE_COUNT_OFS, 32'h0000_0003);
        wr(LOW_PHASE_COUNT_OFS, 32'h0000_0001);
        idle(200);
        rd_chk(HIGH_PHASE_COUNT_OFS, 32'h0000_0007);
        rd_chk(LOW_PHASE_COUNT_OFS, 32'h0000_0001);
        measure(exp_cyc(8, 0, 0), exp_cyc(2, 0, 0));
        wr(HIGH_PHASE_COUNT_OFS, 32'h0000_0009);
        idle(200);
        rd_chk(HIGH_PHASE_COUNT_OFS, 32'h0000_0007);
        wr(LOW_PHASE_COUNT_OFS, 32'h0000_0000);
        idle(100);
        rd_chk(LOW_PHASE_COUNT_OFS, 32'h0000_0000);
        steady(1'b1, 200);
        wr(HIGH_PHASE_COUNT_OFS, 32'h0000_0000);
        wr(LOW_PHASE_COUNT_OFS, 32'h0000_0005);
        idle(2);
        rd_chk(LOW_PHASE_COUNT_OFS, 32'h0000_0005);
        idle(4);
        steady(1'b0, 300);
        wr(HIGH_PHASE_COUNT_OFS, 32'h0000_0001);
        wr(LOW_PHASE_COUNT_OFS, 32'h0000_0001);
        idle(200);
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0003);
        measure(exp_cyc(2, 0, 1), exp_cyc(2, 0, 1));
        wr(HIGH_PHASE_COUNT_OFS, 32'h0000_0003);
        wr(LOW_PHASE_COUNT_OFS, 32'h0000_0005);
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0005);
        measure(exp_cyc(6, 0, 0), exp_cyc(4, 0, 0));
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0004);
        idle(4);
        steady(1'b1, 200);
        rd_chk(HIGH_PHASE_COUNT_OFS, 32'h0000_0003);
        wr(GENERATOR_CONFIGURATION_OFS, 32'h0000_0001);
        idle(100);
        sleep_req <= 1'b1;
        idle(4);
        steady(1'b0, 200);
        sleep_req <= 1'b0;
        measure(exp_cyc(4, 0, 0), exp_cyc(6, 0, 0));
        report_and_stop();
    end
endmodule : fan_led_pwm_generator_test
